// ===== common/tcofc_pkg.sv
// constants and carrier types for the channel-3 override, counter and flag-clear block
`default_nettype none
package tcofc_pkg;
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFF_MODE = 5'h00;
    localparam logic [4:0] OFF_MASK = 5'h02;
    localparam logic [4:0] OFF_DATA = 5'h03;
    localparam logic [4:0] OFF_CNT_HI = 5'h04;
    localparam logic [4:0] OFF_CNT_LO = 5'h05;
    localparam logic [4:0] OFF_SCTL = 5'h06;
    localparam logic [4:0] OFF_CHFLG = 5'h0E;
    localparam logic [4:0] OFF_OVFLG = 5'h0F;
    localparam logic [4:0] OFF_CHAN_BASE = 5'h10;
    localparam logic [4:0] OFF_PAFLG = 5'h19;
    localparam logic [4:0] OFF_PACNT_HI = 5'h1A;
    localparam logic [4:0] OFF_PACNT_LO = 5'h1B;
    localparam logic [4:0] OFF_PORT = 5'h1D;
    localparam logic [4:0] OFF_DDR = 5'h1E;
    localparam int BIT_RUN = 7;
    localparam int BIT_FAST = 4;
    localparam int BIT_OVF = 7;
    localparam int BIT_PULSE_ACC_OVERFLOW_FLAG = 1;
    localparam int BIT_PULSE_ACC_INPUT_FLAG = 0;
    localparam logic [3:0] RST_NIB = 4'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_CNT = 16'h0000;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic wr;
        logic rd;
        logic word;
        logic [15:0] wdata;
    } tcofc_req_t;
endpackage
`default_nettype wire

// ===== logic/tcofc_top.sv
// channel-3 output-compare override, free-running counter and fast flag clearing
//
// Overview of operation
// - set mask bit makes its pin an output while channel is output-compare.
// - mask bits never alter the stored data direction bits.
// - channel-3 compare copies masked data bits into the port data register.
// - channel-3 masked actions win over simultaneous channel 2..0 compare actions.
// - counter reads return the count; writes only act in test mode.
// - counter write takes precedence over a tick, delaying the first count.
// - run enable bit 7 runs timer; cleared, counter and events stop.
// - fast clear bit 4 selects fast clearing for all three flag registers.
// - fast clear: capture read or compare write clears that channel flag.
// - fast clear: any counter byte access clears the overflow flag.
// - fast clear: pulse-accumulator counter access clears both accumulator flags.
// - writing ones clears flags only while fast clearing is off.
// - mode bit set selects output compare, cleared selects input capture.
`timescale 1ns/10ps
`default_nettype none
module tcofc_top (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // register port
    input wire tcofc_pkg::tcofc_req_t REQ,
    output logic [15:0] RDATA,
    // timer core events
    input wire logic TEST_MODE,
    input wire logic PRESCALE_TICK,
    input wire logic CH3_MATCH,
    input wire logic [2:0] CMP_ACT,
    input wire logic [2:0] CMP_LEVEL,
    input wire logic [3:0] CH_EVENT,
    input wire logic PA_OVF_EVENT,
    input wire logic PA_IN_EVENT,
    // flags
    output logic [3:0] CH_FLAGS,
    output logic OVF_FLAG,
    output logic [1:0] PA_FLAGS,
    // timer port pins
    input wire logic [3:0] TP_IN,
    output logic [3:0] TP_OUT,
    output logic [3:0] TP_OE
);
    import tcofc_pkg::*;

    // ************************************************************
    // register state
    // ************************************************************
    logic [3:0] channel_mode_select;
    logic [3:0] ch3_override_mask_bits;
    logic [3:0] ch3_override_data_bits;
    logic [15:0] count_value;
    logic timer_run_enable;
    logic fast_flag_clear_select;
    logic [3:0] port_data;
    logic [3:0] port_ddr;

    function automatic logic hit(input tcofc_req_t r, input logic [4:0] a);
        hit = (r.wr || r.rd) && (r.addr == a);
    endfunction

    logic acc;
    logic [1:0] chan_sel;
    logic cnt_acc, pacnt_acc, chan_acc;
    logic wr_hi, wr_lo;
    assign acc = REQ.wr || REQ.rd;
    assign chan_sel = REQ.addr[2:1];
    assign chan_acc = acc && (REQ.addr[4:3] == OFF_CHAN_BASE[4:3]);
    assign cnt_acc = hit(REQ, OFF_CNT_HI) || hit(REQ, OFF_CNT_LO);
    assign pacnt_acc = hit(REQ, OFF_PACNT_HI) || hit(REQ, OFF_PACNT_LO);
    assign wr_hi = REQ.wr && REQ.addr == OFF_CNT_HI;
    assign wr_lo = REQ.wr && (REQ.addr == OFF_CNT_LO || (REQ.word && REQ.addr == OFF_CNT_HI));

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            channel_mode_select <= RST_NIB;
            ch3_override_mask_bits <= RST_NIB;
            ch3_override_data_bits <= RST_NIB;
            port_ddr <= RST_NIB;
            timer_run_enable <= 1'b0;
            fast_flag_clear_select <= 1'b0;
        end else if (REQ.wr) begin
            case (REQ.addr)
                OFF_MODE: channel_mode_select <= REQ.wdata[3:0];
                OFF_MASK: ch3_override_mask_bits <= REQ.wdata[3:0];
                OFF_DATA: ch3_override_data_bits <= REQ.wdata[3:0];
                OFF_DDR: port_ddr <= REQ.wdata[3:0];
                OFF_SCTL: begin
                    timer_run_enable <= REQ.wdata[BIT_RUN];
                    fast_flag_clear_select <= REQ.wdata[BIT_FAST];
                end
                default: ;
            endcase
        end
    end

    // ************************************************************
    // free-running counter
    // ************************************************************
    logic wrap;
    assign wrap = timer_run_enable && PRESCALE_TICK && (count_value == 16'hFFFF);

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            count_value <= RST_CNT;
        end else if (TEST_MODE && (wr_hi || wr_lo)) begin
            // a write wins over a tick landing in the same cycle
            if (wr_hi) begin
                count_value[15:8] <= REQ.word ? REQ.wdata[15:8] : REQ.wdata[7:0];
            end
            if (wr_lo) begin
                count_value[7:0] <= REQ.wdata[7:0];
            end
        end else if (timer_run_enable && PRESCALE_TICK) begin
            count_value <= count_value + 16'h0001;
        end
    end

    // ************************************************************
    // flags
    // ************************************************************
    logic [3:0] ch_clr;
    logic ovf_clr;
    logic pa_clr_ovf, pa_clr_in;
    always_comb begin
        ch_clr = 4'h0;
        ovf_clr = 1'b0;
        pa_clr_ovf = 1'b0;
        pa_clr_in = 1'b0;
        if (fast_flag_clear_select) begin
            if (chan_acc && ((REQ.rd && !channel_mode_select[chan_sel])
                    || (REQ.wr && channel_mode_select[chan_sel]))) begin
                ch_clr[chan_sel] = 1'b1;
            end
            ovf_clr = cnt_acc;
            pa_clr_ovf = pacnt_acc;
            pa_clr_in = pacnt_acc;
        end else if (REQ.wr) begin
            if (REQ.addr == OFF_CHFLG) ch_clr = REQ.wdata[3:0];
            if (REQ.addr == OFF_OVFLG) ovf_clr = REQ.wdata[BIT_OVF];
            if (REQ.addr == OFF_PAFLG) begin
                pa_clr_ovf = REQ.wdata[BIT_PULSE_ACC_OVERFLOW_FLAG];
                pa_clr_in = REQ.wdata[BIT_PULSE_ACC_INPUT_FLAG];
            end
        end
    end

    // a set arriving with its clear wins
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            CH_FLAGS <= RST_NIB;
            OVF_FLAG <= 1'b0;
            PA_FLAGS <= 2'b00;
        end else begin
            CH_FLAGS <= (CH_FLAGS & ~ch_clr) | (CH_EVENT & {4{timer_run_enable}});
            OVF_FLAG <= (OVF_FLAG & ~ovf_clr) | wrap;
            PA_FLAGS[BIT_PULSE_ACC_OVERFLOW_FLAG] <= (PA_FLAGS[BIT_PULSE_ACC_OVERFLOW_FLAG] & ~pa_clr_ovf)
                | (PA_OVF_EVENT & timer_run_enable);
            PA_FLAGS[BIT_PULSE_ACC_INPUT_FLAG] <= (PA_FLAGS[BIT_PULSE_ACC_INPUT_FLAG] & ~pa_clr_in)
                | (PA_IN_EVENT & timer_run_enable);
        end
    end

    // ************************************************************
    // port data and pin direction
    // ************************************************************
    logic [3:0] next_port;
    logic ch3_fire;
    assign ch3_fire = timer_run_enable && CH3_MATCH && channel_mode_select[3];
    always_comb begin
        next_port = port_data;
        if (REQ.wr && REQ.addr == OFF_PORT) begin
            next_port = REQ.wdata[3:0];
        end
        for (int i = 0; i < 3; i++) begin
            if (timer_run_enable && CMP_ACT[i] && channel_mode_select[i]) begin
                next_port[i] = CMP_LEVEL[i];
            end
        end
        if (ch3_fire) begin
            // applied last so it overrides channels 2..0
            next_port = (next_port & ~ch3_override_mask_bits)
                | (ch3_override_data_bits & ch3_override_mask_bits);
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            port_data <= RST_NIB;
            TP_OUT <= RST_NIB;
            TP_OE <= RST_NIB;
        end else begin
            port_data <= next_port;
            TP_OUT <= next_port;
            TP_OE <= port_ddr | (ch3_override_mask_bits & channel_mode_select);
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            RDATA <= 16'h0000;
        end else if (REQ.rd) begin
            unique case (REQ.addr)
                OFF_MODE: RDATA <= {12'h000, channel_mode_select};
                OFF_MASK: RDATA <= {12'h000, ch3_override_mask_bits};
                OFF_DATA: RDATA <= {12'h000, ch3_override_data_bits};
                OFF_CNT_HI: RDATA <= REQ.word ? count_value : {8'h00, count_value[15:8]};
                OFF_CNT_LO: RDATA <= {8'h00, count_value[7:0]};
                OFF_SCTL: RDATA <= {8'h00, timer_run_enable, 2'b00, fast_flag_clear_select, 4'h0};
                OFF_CHFLG: RDATA <= {12'h000, CH_FLAGS};
                OFF_OVFLG: RDATA <= {8'h00, OVF_FLAG, 7'h00};
                OFF_PAFLG: RDATA <= {14'h0000, PA_FLAGS};
                OFF_PORT: RDATA <= {12'h000, TP_IN};
                OFF_DDR: RDATA <= {12'h000, port_ddr};
                default: RDATA <= 16'h0000;
            endcase
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    pin_output_a: assert property (##1 (TP_OE == $past(port_ddr
        | (ch3_override_mask_bits & channel_mode_select))))
        else $error("pin direction wrong");
    ddr_kept_a: assert property (REQ.wr && REQ.addr == OFF_MASK |=> $stable(port_ddr))
        else $error("mask write changed direction");
    ch3_copy_a: assert property (ch3_fire |=> ((TP_OUT & $past(ch3_override_mask_bits))
        == ($past(ch3_override_data_bits) & $past(ch3_override_mask_bits))))
        else $error("channel 3 data not copied");
    cnt_nowrite_a: assert property (!TEST_MODE && !(timer_run_enable && PRESCALE_TICK)
        |=> $stable(count_value))
        else $error("counter changed without tick");
    cnt_stop_a: assert property (!timer_run_enable && !TEST_MODE |=> $stable(count_value))
        else $error("stopped counter moved");
    cnt_tick_a: assert property (timer_run_enable && PRESCALE_TICK && !(TEST_MODE && REQ.wr)
        |=> count_value == $past(count_value) + 16'h0001)
        else $error("counter did not advance");
    ovf_fast_a: assert property (fast_flag_clear_select && cnt_acc && !wrap |=> !OVF_FLAG)
        else $error("fast clear of overflow missed");
    pa_fast_a: assert property (fast_flag_clear_select && pacnt_acc && !PA_OVF_EVENT
        && !PA_IN_EVENT |=> PA_FLAGS == 2'b00)
        else $error("fast clear of accumulator flags missed");
    w1c_fast_a: assert property (fast_flag_clear_select && REQ.wr && REQ.addr == OFF_CHFLG
        && CH_FLAGS[0] |=> CH_FLAGS[0])
        else $error("write cleared flag in fast mode");
    ch_fast_a: assert property (fast_flag_clear_select && chan_acc && REQ.rd
        && !channel_mode_select[chan_sel] && !CH_EVENT[chan_sel]
        |=> !CH_FLAGS[$past(chan_sel)])
        else $error("capture read did not clear flag");
    wrap_c: cover property (wrap ##1 OVF_FLAG);
    ch3_c: cover property (ch3_fire && CMP_ACT != 3'b000);
    fast_c: cover property (fast_flag_clear_select && cnt_acc && OVF_FLAG);
endmodule // tcofc_top
`default_nettype wire

// ===== verification/tcofc_cpu_model.sv
// processor-side model that issues register accesses to the block
`timescale 1ns/10ps
`default_nettype none
module tcofc_cpu_model
    import tcofc_pkg::*;
(
    // clock
    input wire logic clk,
    // register port
    output var tcofc_pkg::tcofc_req_t req,
    input wire logic [15:0] rdata
);
    initial req = '0;
    // one strobe pulse; an idle cycle first so two strobes never merge
    task automatic access(input logic [4:0] a, input logic w, input logic wd,
        input logic [15:0] d, output logic [15:0] q);
        @(posedge clk);
        #1;
        req = '{a, w, !w, wd, d};
        @(posedge clk);
        #1;
        req = '0;
        q = rdata;
    endtask
    // reserved upper bits always written as zero
    task automatic wr_nib(input logic [4:0] a, input logic [3:0] d);
        logic [15:0] q;
        access(a, 1'b1, 1'b0, {12'h000, d}, q);
    endtask
endmodule // tcofc_cpu_model
`default_nettype wire

// ===== verification/timer_ch3_override_and_flag_clear_test.sv
// self-checking bench for the override, counter and flag-clear block
`timescale 1ns/10ps
`default_nettype none
module timer_ch3_override_and_flag_clear_test;
    import tcofc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    tcofc_req_t req;
    logic [15:0] rdata, q;
    logic tmode = 1'b0, tick = 1'b0, m3 = 1'b0, pao = 1'b0, pai = 1'b0, ovf;
    logic [2:0] act = '0, lvl = '0;
    logic [3:0] chev = '0, tpin = '0, tpout, tpoe, chf;
    logic [1:0] paf;
    int fails = 0, checked = 0, seed = 32'hF5021E06, cnt = 0, n;
    always #10 clk = ~clk;
    tcofc_top dut (.REF_CLK(clk), .RST(rst), .REQ(req), .RDATA(rdata), .TEST_MODE(tmode),
        .PRESCALE_TICK(tick), .CH3_MATCH(m3), .CMP_ACT(act), .CMP_LEVEL(lvl),
        .CH_EVENT(chev), .PA_OVF_EVENT(pao), .PA_IN_EVENT(pai), .CH_FLAGS(chf),
        .OVF_FLAG(ovf), .PA_FLAGS(paf), .TP_IN(tpin), .TP_OUT(tpout), .TP_OE(tpoe));
    tcofc_cpu_model cpu (.clk(clk), .req(req), .rdata(rdata));
    // ****************************************
    // compare, access and event tasks
    // ****************************************
    task automatic compare(input string s, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk_rd(input logic [4:0] a, input logic wd, input logic [15:0] e);
        cpu.access(a, 1'b0, wd, 16'h0000, q);
        compare($sformatf("reg %h", a), e, q);
    endtask
    // vector is {tick, ch3 match, act, level, channel events, acc ovf, acc input}
    task automatic ev(input logic [13:0] v);
        @(posedge clk);
        #1;
        {tick, m3, act, lvl, chev, pao, pai} = v;
        @(posedge clk);
        #1;
        {tick, m3, act, lvl, chev, pao, pai} = '0;
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic print_verdict;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        print_verdict;
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        tpin = 4'($random(seed));
        chk_rd(OFF_MASK, 1'b0, 16'h0000);
        chk_rd(OFF_CNT_HI, 1'b1, 16'h0000);
        chk_rd(OFF_PORT, 1'b0, {12'h000, tpin});
        cpu.access(OFF_SCTL, 1'b1, 1'b0, 16'h0090, q);
        chk_rd(OFF_SCTL, 1'b0, 16'h0090);
        cpu.wr_nib(OFF_MODE, 4'hF);
        cpu.wr_nib(OFF_MASK, 4'h3);
        cpu.wr_nib(OFF_DATA, 4'h1);
        idle(2);
        compare("oe", 16'h0003, {12'h000, tpoe});
        chk_rd(OFF_DDR, 1'b0, 16'h0000);
        cpu.wr_nib(OFF_PORT, 4'hA);
        compare("port", 16'h000A, {12'h000, tpout});
        // bits 1..0 from override data, bit 2 from channel 2, bit 3 kept from the write
        ev({1'b0, 1'b1, 3'b111, 3'b110, 4'h0, 2'b00});
        compare("port", 16'h000D, {12'h000, tpout});
        cpu.wr_nib(OFF_MODE, 4'hE);
        idle(2);
        compare("oe", 16'h0002, {12'h000, tpoe});
        n = 1 + ($unsigned($random(seed)) % 40);
        repeat (n) ev({1'b1, 13'h0000});
        cnt = n;
        chk_rd(OFF_CNT_HI, 1'b1, 16'(cnt));
        q = 16'($random(seed));
        cpu.access(OFF_CNT_HI, 1'b1, 1'b1, q, q);
        chk_rd(OFF_CNT_HI, 1'b1, 16'(cnt));
        n = $random(seed);
        tmode = 1'b1;
        cpu.access(OFF_CNT_HI, 1'b1, 1'b1, 16'(n), q);
        tmode = 1'b0;
        chk_rd(OFF_CNT_HI, 1'b1, 16'(n));
        tmode = 1'b1;
        cpu.access(OFF_CNT_LO, 1'b1, 1'b0, 16'h00A5, q);
        tmode = 1'b0;
        chk_rd(OFF_CNT_HI, 1'b0, {8'h00, n[15:8]});
        chk_rd(OFF_CNT_LO, 1'b0, 16'h00A5);
        tmode = 1'b1;
        cpu.access(OFF_CNT_HI, 1'b1, 1'b1, 16'hFFFF, q);
        tmode = 1'b0;
        ev({1'b1, 13'h0000});
        idle(1);
        compare("ovf", 16'h0001, {15'h0000, ovf});
        cpu.access(OFF_OVFLG, 1'b1, 1'b0, 16'h0080, q);
        idle(2);
        compare("ovf", 16'h0001, {15'h0000, ovf});
        chk_rd(OFF_CNT_LO, 1'b0, 16'h0000);
        idle(2);
        compare("ovf", 16'h0000, {15'h0000, ovf});
        ev({8'h00, 4'hF, 2'b11});
        idle(1);
        compare("chf", 16'h000F, {12'h000, chf});
        compare("paf", 16'h0003, {14'h0000, paf});
        cpu.access(OFF_CHAN_BASE + 5'h06, 1'b1, 1'b0, 16'h0012, q);
        cpu.access(OFF_CHAN_BASE, 1'b0, 1'b0, 16'h0000, q);
        cpu.access(OFF_PACNT_HI, 1'b0, 1'b0, 16'h0000, q);
        idle(2);
        compare("chf", 16'h0006, {12'h000, chf});
        compare("paf", 16'h0000, {14'h0000, paf});
        // writing ones in fast mode must leave a set flag alone
        ev({8'h00, 4'h1, 2'b00});
        cpu.access(OFF_CHFLG, 1'b1, 1'b0, 16'h000F, q);
        idle(2);
        compare("chf", 16'h0007, {12'h000, chf});
        cpu.access(OFF_SCTL, 1'b1, 1'b0, 16'h0080, q);
        cpu.access(OFF_CHFLG, 1'b1, 1'b0, 16'h0002, q);
        idle(2);
        compare("chf", 16'h0005, {12'h000, chf});
        ev({8'h00, 4'h0, 2'b11});
        cpu.access(OFF_PAFLG, 1'b1, 1'b0, 16'h0002, q);
        idle(2);
        compare("paf", 16'h0001, {14'h0000, paf});
        cpu.access(OFF_SCTL, 1'b1, 1'b0, 16'h0000, q);
        repeat (3) ev({1'b1, 7'h00, 4'h2, 2'b10});
        idle(1);
        compare("chf", 16'h0005, {12'h000, chf});
        compare("paf", 16'h0001, {14'h0000, paf});
        chk_rd(OFF_CNT_HI, 1'b1, 16'h0000);
        print_verdict;
    end
endmodule // timer_ch3_override_and_flag_clear_test
`default_nettype wire
